/* File: dv/isaio_isa_peer.sv */
`timescale 1ns/1ps
module isaio_isa_peer
(
    // bus side
    input  wire logic ref_clk_i,
    input  wire logic arst_n_i,
    input  wire logic go_i,
    output logic      end_o
);
    // command held a few clocks before its rising edge
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    always_comb cnt_d = go_i ? 2'h3 : cnt_q - {1'b0, cnt_q != 2'h0};
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_d;
    assign end_o = cnt_q == 2'h1;
endmodule : isaio_isa_peer

/* File: dv/isaio_monitor.sv */
`timescale 1ns/1ps
module isaio_monitor
(
    // clock and reset
    input wire logic                 ref_clk_i,
    input wire logic                 arst_n_i,
    // apb
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [11:0]          paddr_i,
    input wire logic [31:0]          pwdata_i,
    input wire logic [3:0]           pstrb_i,
    input wire logic [31:0]          prdata_o,
    // io decode and recovery
    input wire isaio_pkg::isaio_io_t io_req_i,
    input wire logic                 io_forward_o,
    input wire logic                 io_ignore_o,
    input wire logic                 fast_off_reload_o,
    input wire logic                 io_cmd_sub_i,
    input wire logic                 io_cmd_end_i,
    input wire logic                 io_recovering_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic alias_q;
    logic hit9;
    assign hit9 = io_req_i.valid && io_req_i.port[7:4] == 4'h9 && !io_req_i.isa_master;
    // shadow of the aliasing bit, written on the apb access edge
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            alias_q <= 1'b0;
        else if (psel_i && penable_i && pwrite_i && pstrb_i[0]
                 && paddr_i == isaio_pkg::isaio_addr_recovery)
            alias_q <= pwdata_i[7];
    property p_rec_min;
        io_cmd_end_i && !io_cmd_sub_i |=> io_recovering_o [*7];
    endproperty
    a_rec_min: assert property (p_rec_min) else $error("recovery too short");
    property p_sub;
        io_cmd_end_i && io_cmd_sub_i |=> !io_recovering_o;
    endproperty
    a_sub: assert property (p_sub) else $error("recovery after sub-cycle");
    property p_class;
        psel_i && !penable_i && !pwrite_i && paddr_i == isaio_pkg::isaio_addr_class
            |=> prdata_o == 32'h0006_0100;
    endproperty
    a_class: assert property (p_class) else $error("class id wrong");
    property p_header;
        psel_i && !penable_i && !pwrite_i && paddr_i == isaio_pkg::isaio_addr_header
            |=> prdata_o == 32'h0000_0080;
    endproperty
    a_header: assert property (p_header) else $error("header kind wrong");
    property p_alias_off;
        hit9 && !alias_q && !io_req_i.write && io_req_i.port != 8'h92 |=> !io_forward_o;
    endproperty
    a_alias_off: assert property (p_alias_off) else $error("aliased read forwarded");
    property p_alias_on;
        hit9 && alias_q |=> io_forward_o && !fast_off_reload_o;
    endproperty
    a_alias_on: assert property (p_alias_on) else $error("unaliased access wrong");
    property p_port92;
        hit9 && io_req_i.port == 8'h92 |=> io_forward_o;
    endproperty
    a_port92: assert property (p_port92) else $error("port 92h not forwarded");
    property p_isa_ign;
        io_req_i.valid && io_req_i.isa_master && io_req_i.port[7:4] == 4'h9 && alias_q
            |=> io_ignore_o;
    endproperty
    a_isa_ign: assert property (p_isa_ign) else $error("isa master not ignored");
endmodule : isaio_monitor
bind isaio_top isaio_monitor u_mon (.ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .io_req_i, .io_forward_o, .io_ignore_o,
    .fast_off_reload_o, .io_cmd_sub_i, .io_cmd_end_i, .io_recovering_o);

/* File: dv/isaio_top_bench.sv */
`timescale 1ns/1ps
module isaio_top_bench;
    logic                 clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic                 fwd, ign, rld, req, is8, sub, cmd_end, go, recov, xout_en_n;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [3:0]           pstrb;
    logic [1:0]           hit, sel_n;
    isaio_pkg::isaio_io_t io_req;
    int                   err_total, check_count, i;
    isaio_top u_dut (.ref_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .io_req_i(io_req),
        .io_forward_o(fwd), .io_ignore_o(ign), .fast_off_reload_o(rld), .io_cmd_req_i(req),
        .io_cmd_8bit_i(is8), .io_cmd_sub_i(sub), .io_cmd_end_i(cmd_end), .io_cmd_go_o(go),
        .io_recovering_o(recov), .sel_hit_i(hit), .sel_n_o(sel_n),
        .xbus_output_enable_n_o(xout_en_n));
    isaio_isa_peer u_peer (.ref_clk_i(clk), .arst_n_i(rst_n), .go_i(go), .end_o(cmd_end));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one command, then count the clocks spent recovering after it
    task automatic rec(input logic [7:0] v, input logic b, input logic sb, input int add);
        int n;
        apb(1'b1, isaio_pkg::isaio_addr_recovery, {24'h0, v}, 4'h1);
        is8 <= b; sub <= sb; req <= 1'b1;
        do @(posedge clk); while (go !== 1'b1);
        req <= 1'b0;
        do @(posedge clk); while (cmd_end !== 1'b1);
        n = 0;
        @(posedge clk);
        while (recov === 1'b1 && n < 60)
        begin
            n++;
            @(posedge clk);
        end
        check(32'(n), sb ? 32'd0 : 32'(7 + 2 * add));
    endtask : rec
    // a write during recovery must leave the running interval alone
    task automatic rec_hold;
        int n;
        apb(1'b1, isaio_pkg::isaio_addr_recovery, 32'h48, 4'h1);
        is8 <= 1'b1; sub <= 1'b0; req <= 1'b1;
        do @(posedge clk); while (go !== 1'b1);
        req <= 1'b0;
        do @(posedge clk); while (cmd_end !== 1'b1);
        n = 0;
        fork
            apb(1'b1, isaio_pkg::isaio_addr_recovery, 32'h40, 4'h1);
            begin
                @(posedge clk);
                while (recov === 1'b1 && n < 60)
                begin
                    n++;
                    @(posedge clk);
                end
            end
        join
        check(32'(n), 32'd9);
    endtask : rec_hold
    task automatic io(input logic [7:0] p, input logic w, input logic m, input logic [2:0] k,
                      input logic [2:0] x);
        @(posedge clk);
        io_req <= '{1'b1, w, m, p};
        @(posedge clk);
        io_req <= '0;
        @(posedge clk);
        check({29'h0, {fwd, ign, rld} & k}, {29'h0, x});
    endtask : io
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, req, is8, sub, hit} = '0;
        io_req = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, isaio_pkg::isaio_addr_class, 32'hffff_ffff, 4'hf);
        apb(1'b0, isaio_pkg::isaio_addr_class, 32'h0, 4'h0);
        check(rd, 32'h0006_0100);
        apb(1'b1, isaio_pkg::isaio_addr_header, 32'hffff_ffff, 4'hf);
        apb(1'b0, isaio_pkg::isaio_addr_header, 32'h0, 4'h0);
        check(rd, 32'h0000_0080);
        apb(1'b0, isaio_pkg::isaio_addr_recovery, 32'h0, 4'h0);
        check(rd, 32'h0000_004d);
        apb(1'b0, 12'h100, 32'h0, 4'h0);
        check({31'h0, er}, 32'h1);
        rec(8'h4d, 1'b1, 1'b1, 0);
        for (i = 0; i < 8; i++)
            rec(8'h40 | 8'(i << 3), 1'b1, 1'b0, i == 0 ? 8 : i);
        rec(8'h3f, 1'b1, 1'b0, 0);
        for (i = 0; i < 4; i++)
            rec(8'h04 | 8'(i), 1'b0, 1'b0, i == 0 ? 4 : i);
        rec(8'h7b, 1'b0, 1'b0, 0);
        rec_hold();
        apb(1'b1, isaio_pkg::isaio_addr_recovery, 32'h4d, 4'h1);
        io(8'h95, 1'b1, 1'b0, 3'b100, 3'b100);
        io(8'h95, 1'b0, 1'b0, 3'b100, 3'b000);
        io(8'h92, 1'b0, 1'b0, 3'b100, 3'b100);
        apb(1'b1, isaio_pkg::isaio_addr_recovery, 32'hcd, 4'h1);
        io(8'h95, 1'b0, 1'b0, 3'b111, 3'b100);
        io(8'h9f, 1'b0, 1'b1, 3'b111, 3'b010);
        io(8'h92, 1'b0, 1'b0, 3'b111, 3'b100);
        hit <= 2'b01;
        repeat (2) @(posedge clk);
        check({29'h0, xout_en_n, sel_n}, 32'h2);
        hit <= 2'b00;
        apb(1'b1, isaio_pkg::isaio_addr_xsel, 32'h0, 4'h3);
        hit <= 2'b11;
        repeat (2) @(posedge clk);
        check({29'h0, xout_en_n, sel_n}, 32'h7);
        report_and_stop();
    end
endmodule : isaio_top_bench

/* File: verilog/isaio_pkg.sv */
// How it works
// RQ1: class id reads 060100h, read only
// RQ2: header kind reads 80h, read only
// RQ3: at least 3.5 sysclks between io commands
// RQ4: interval runs from command rise to fall
// RQ5: no extra delay between byte sub-cycles
// RQ6: bit 6 enables programmed 8-bit recovery
// RQ7: 8-bit field codes 1-7, 000 is 8
// RQ8: bit 2 enables programmed 16-bit recovery
// RQ9: 16-bit field codes 1-3, 00 is 4
// RQ10: recovery register resets to 4dh
// RQ11: alias clear: 90-9fh aliases, writes only forwarded
// RQ12: alias set: 90-9fh forwarded read and write
// RQ13: port 92h always forwarded; code ignores it from an isa master when bit 7 is set
// RQ14: alias set: isa master 90-9fh ignored
// RQ15: alias set: no fast-off reload for 90-9fh
// RQ16: cleared enable blocks select and output enable
// RQ17: new settings apply from next cycle only
package isaio_pkg;
    // register index; the byte address is four times it
    localparam logic [9:0]  isaio_idx_class     = 10'h009;
    localparam logic [9:0]  isaio_idx_header    = 10'h00e;
    localparam logic [9:0]  isaio_idx_recovery  = 10'h04c;
    localparam logic [9:0]  isaio_idx_xsel      = 10'h04e;
    localparam logic [11:0] isaio_addr_class    = {isaio_idx_class, 2'b00};
    localparam logic [11:0] isaio_addr_header   = {isaio_idx_header, 2'b00};
    localparam logic [11:0] isaio_addr_recovery = {isaio_idx_recovery, 2'b00};
    localparam logic [11:0] isaio_addr_xsel     = {isaio_idx_xsel, 2'b00};
    localparam logic [23:0] isaio_class_val     = 24'h060100;
    localparam logic [7:0]  isaio_header_val    = 8'h80;
    localparam logic [7:0]  isaio_recovery_rst  = 8'h4d;
    localparam logic [15:0] isaio_xsel_rst      = 16'h0003;
    localparam int          isaio_alias_bit     = 7;
    localparam int          isaio_en8_bit       = 6;
    localparam int          isaio_t8_lsb        = 3;
    localparam int          isaio_en16_bit      = 2;
    localparam int          isaio_t16_lsb       = 0;
    localparam logic [7:0]  isaio_port_92    = 8'h92;
    localparam logic [3:0]  isaio_page_hi    = 4'h9;
    localparam logic [3:0]  isaio_min_half   = 4'h7;
    localparam int          isaio_xsel_cnt   = 2;

    typedef struct packed {
        logic       en8;
        logic [2:0] t8;
        logic       en16;
        logic [1:0] t16;
    } isaio_rec_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       isa_master;
        logic [7:0] port;
    } isaio_io_t;

    typedef enum logic [1:0] {
        isaio_idle = 2'b00,
        isaio_cmd  = 2'b01,
        isaio_rec  = 2'b11
    } isaio_state_t;

    function automatic logic [4:0] isaio_half_cycles(input isaio_rec_t r, input logic is8);
        logic [3:0] add;
        add = 4'h0;
        if (is8 && r.en8)
            add = (r.t8 == 3'b000) ? 4'h8 : {1'b0, r.t8};
        else if (!is8 && r.en16)
            add = (r.t16 == 2'b00) ? 4'h4 : {2'b00, r.t16};
        return {1'b0, isaio_min_half} + {add, 1'b0};
    endfunction : isaio_half_cycles
endpackage : isaio_pkg

/* File: verilog/isaio_regs.sv */
`timescale 1ns/1ps
module isaio_regs
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // apb
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // register values
    output logic      [7:0]  recovery_o,
    output logic      [15:0] xsel_ctrl_o
);
    logic [7:0]  recov_q, recov_d;
    logic [15:0] xsel_q, xsel_d;
    logic [31:0] rdata_q, rdata_d;
    logic        hit;
    logic        wr;

    assign wr        = psel_i && penable_i && pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign prdata_o  = rdata_q;
    assign recovery_o  = recov_q;
    assign xsel_ctrl_o = xsel_q;

    always_comb
    begin
        recov_d = recov_q;
        xsel_d  = xsel_q;
        rdata_d = rdata_q;
        hit     = 1'b1;
        if (paddr_i == isaio_pkg::isaio_addr_class)
            rdata_d = {8'h00, isaio_pkg::isaio_class_val}; // RQ1
        else if (paddr_i == isaio_pkg::isaio_addr_header)
            rdata_d = {24'h00_0000, isaio_pkg::isaio_header_val}; // RQ2
        else if (paddr_i == isaio_pkg::isaio_addr_recovery)
        begin
            rdata_d = {24'h00_0000, recov_q};
            if (wr && pstrb_i[0])
                recov_d = pwdata_i[7:0];
        end
        else if (paddr_i == isaio_pkg::isaio_addr_xsel)
        begin
            rdata_d = {16'h0000, xsel_q};
            if (wr && pstrb_i[0])
                xsel_d[7:0] = pwdata_i[7:0];
            if (wr && pstrb_i[1])
                xsel_d[15:8] = pwdata_i[15:8];
        end
        else
        begin
            hit     = 1'b0;
            rdata_d = 32'h0000_0000;
        end
        if (!(psel_i && !penable_i && !pwrite_i))
            rdata_d = rdata_q;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            recov_q <= isaio_pkg::isaio_recovery_rst; // RQ10
            xsel_q  <= isaio_pkg::isaio_xsel_rst;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            recov_q <= recov_d;
            xsel_q  <= xsel_d;
            rdata_q <= rdata_d;
        end
    end
endmodule : isaio_regs

/* File: verilog/isaio_top.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module isaio_top
#(
    parameter int xsel_n = isaio_pkg::isaio_xsel_cnt
)
(
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    // apb
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [11:0]           paddr_i,
    input  wire logic [31:0]           pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // io decode
    input  wire isaio_pkg::isaio_io_t  io_req_i,
    output logic                       io_forward_o,
    output logic                       io_ignore_o,
    output logic                       fast_off_reload_o,
    // recovery: ref_clk is twice sysclk, one tick = half sysclk
    input  wire logic                  io_cmd_req_i,
    input  wire logic                  io_cmd_8bit_i,
    input  wire logic                  io_cmd_sub_i,
    input  wire logic                  io_cmd_end_i,
    output logic                       io_cmd_go_o,
    output logic                       io_recovering_o,
    // xbus selects
    input  wire logic [xsel_n-1:0]     sel_hit_i,
    output logic      [xsel_n-1:0]     sel_n_o,
    output logic                       xbus_output_enable_n_o
);
    // the enable field is 16 bits wide, so at most 16 selects
    if (xsel_n < 1 || xsel_n > 16)
    begin : g_bad_xsel
        $error("xsel_n out of range");
    end

    logic [7:0]  recov_reg;
    logic [15:0] xsel_reg;
    isaio_pkg::isaio_rec_t  rec;
    isaio_pkg::isaio_state_t st_q, st_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        is8_q, is8_d;
    logic        fwd_q, fwd_d, ign_q, ign_d, ld_q, ld_d;
    logic [xsel_n-1:0] sel_q, sel_d;
    logic        xout_en_n_q, xout_en_n_d;
    logic        in_page, alias_off;

    isaio_regs u_regs
    (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .pstrb_i   (pstrb_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .recovery_o  (recov_reg),
        .xsel_ctrl_o (xsel_reg)
    );

    assign rec = '{en8: recov_reg[isaio_pkg::isaio_en8_bit],
                   t8: recov_reg[isaio_pkg::isaio_t8_lsb +: 3],
                   en16: recov_reg[isaio_pkg::isaio_en16_bit],
                   t16: recov_reg[isaio_pkg::isaio_t16_lsb +: 2]};
    assign alias_off = recov_reg[isaio_pkg::isaio_alias_bit];
    assign in_page   = io_req_i.port[7:4] == isaio_pkg::isaio_page_hi;

    // page range decode
    always_comb
    begin
        fwd_d = 1'b0;
        ign_d = 1'b0;
        // port 92h lies inside the page range, so it gets no reload either
        ld_d  = io_req_i.valid && !(in_page && alias_off); // RQ15
        if (!io_req_i.valid)
            fwd_d = 1'b0;
        else if (in_page && alias_off && io_req_i.isa_master)
            ign_d = 1'b1; // RQ14
        else if (io_req_i.port == isaio_pkg::isaio_port_92)
            fwd_d = 1'b1; // RQ13
        else if (in_page && alias_off)
            fwd_d = 1'b1; // RQ12
        else if (in_page)
            fwd_d = io_req_i.write; // RQ11
        else
            fwd_d = 1'b1;
    end

    // recovery timer: the load happens only at command end, so a register
    // write mid-interval never disturbs it
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        is8_d = is8_q;
        io_cmd_go_o = 1'b0;
        case (st_q)
            isaio_pkg::isaio_idle:
            begin
                if (io_cmd_req_i)
                begin
                    io_cmd_go_o = 1'b1;
                    is8_d = io_cmd_8bit_i;
                    st_d  = isaio_pkg::isaio_cmd;
                end
            end
            isaio_pkg::isaio_cmd:
            begin
                if (io_cmd_end_i && io_cmd_sub_i)
                    st_d = isaio_pkg::isaio_idle; // RQ5
                else if (io_cmd_end_i)
                begin
                    cnt_d = isaio_pkg::isaio_half_cycles(rec, is8_q); // RQ4 RQ6 RQ7 RQ8 RQ9 RQ17
                    st_d  = isaio_pkg::isaio_rec;
                end
            end
            isaio_pkg::isaio_rec:
            begin
                if (cnt_q > 5'd1)
                    cnt_d = cnt_q - 5'd1; // RQ3
                else
                    st_d = isaio_pkg::isaio_idle;
            end
            default:
                st_d = isaio_pkg::isaio_idle;
        endcase
    end
    assign io_recovering_o = st_q == isaio_pkg::isaio_rec;

    // chip selects gated by their enable bits
    always_comb
    begin
        sel_d       = ~(sel_hit_i & xsel_reg[xsel_n-1:0]); // RQ16
        xout_en_n_d = &sel_d; // RQ16
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fwd_q <= 1'b0;
            ign_q <= 1'b0;
            ld_q  <= 1'b0;
        end
        else
        begin
            fwd_q <= fwd_d;
            ign_q <= ign_d;
            ld_q  <= ld_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q  <= isaio_pkg::isaio_idle;
            cnt_q <= 5'd0;
            is8_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            is8_q <= is8_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sel_q       <= '1;
            xout_en_n_q <= 1'b1;
        end
        else
        begin
            sel_q       <= sel_d;
            xout_en_n_q <= xout_en_n_d;
        end
    end

    assign io_forward_o           = fwd_q;
    assign io_ignore_o            = ign_q;
    assign fast_off_reload_o      = ld_q;
    assign sel_n_o                = sel_q;
    assign xbus_output_enable_n_o = xout_en_n_q;
endmodule : isaio_top
